// ===== logic/instr_dec_pkg.sv
/*
 * Constants, field layouts and state types for the 14-bit instruction
 * decoder and sequencer. Assumes one core clock in which every
 * instruction cycle spans four clocks.
 */
// What this block does
// RULE1 - Take 14-bit instruction words made of an opcode and operand fields.
// RULE2 - Destination bit 0 puts the result in the accumulator, 1 in the register.
// RULE3 - Register address field is seven bits, 0x00 to 0x7F.
// RULE4 - Literal and control constants are 8 or 11 bits wide.
// RULE5 - One instruction cycle lasts exactly four core clocks.
// RULE6 - True tests and program flow changes take two cycles; the second is idle.
// RULE7 - Every register instruction reads its register first, even pure writes.
// RULE8 - Clearing a port register still reads it, clearing its pin-change mismatch.
// RULE9 - Don't-care opcode bits are ignored whatever their value.
// RULE10 - Byte ops top bits 00; add 0111, subtract 0010 update carry, digit carry, zero.
// RULE11 - OR 0100, XOR 0110, AND 0101 update only the zero flag.
// RULE12 - Rotates 1101 left, 1100 right go through carry and update only carry.
// RULE13 - Decrement/increment skip-if-zero 1011/1111 skip on zero, flags untouched.
// RULE14 - Decrement, increment, complement, move and clears update the zero flag.
// RULE15 - Swap 1110 exchanges nibbles; 0000 with bit 7 stores accumulator, else idle.
// RULE16 - Bit ops top bits 01: clear 00, set 01, skip-if-clear 10, skip-if-set 11.
// RULE17 - Standby word 0x0063 enters standby and updates time-out and power-down bits.

package instr_dec_pkg;

    // Instruction word layout
    localparam int INSTR_W = 14;
    localparam int FADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int TARGET_W = 11;
    localparam int CYCLE_CLKS = 4;

    // Top two opcode bits select the group
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_BRANCH = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;

    // Byte-oriented operation nibbles
    localparam logic [3:0] OP_MISC = 4'h0;
    localparam logic [3:0] OP_CLEAR = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_DEC = 4'h3;
    localparam logic [3:0] OP_OR = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_XOR = 4'h6;
    localparam logic [3:0] OP_ADD = 4'h7;
    localparam logic [3:0] OP_MOVE = 4'h8;
    localparam logic [3:0] OP_COMPL = 4'h9;
    localparam logic [3:0] OP_INC = 4'ha;
    localparam logic [3:0] OP_DEC_SKIP = 4'hb;
    localparam logic [3:0] OP_ROT_RIGHT = 4'hc;
    localparam logic [3:0] OP_ROT_LEFT = 4'hd;
    localparam logic [3:0] OP_SWAP = 4'he;
    localparam logic [3:0] OP_INC_SKIP = 4'hf;

    // Control words inside the 0000 nibble with bit 7 clear
    localparam logic [7:0] MISC_RETURN = 8'h08;
    localparam logic [7:0] MISC_RET_INT = 8'h09;
    localparam logic [7:0] MISC_STANDBY = 8'h63;
    localparam logic [7:0] MISC_WDT_CLEAR = 8'h64;

    // Bit-op and literal sub-codes
    localparam logic [1:0] BIT_CLEAR = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_SKIP_CLR = 2'h2;
    localparam logic [1:0] BIT_SKIP_SET = 2'h3;
    localparam logic [1:0] LIT_MOVE = 2'h0;
    localparam logic [1:0] LIT_RETURN = 2'h1;
    localparam logic [1:0] LIT_LOGIC = 2'h2;
    localparam logic [1:0] LIT_ARITH = 2'h3;

    typedef enum logic [1:0] {PH_FETCH, PH_READ, PH_EXEC, PH_WRITE} phase_t;

    typedef struct packed {
        logic timeout_status_bit;
        logic powerdown_status_bit;
        logic z;
        logic digit_carry_flag;
        logic c;
    } status_t;

    typedef struct packed {
        logic jump;
        logic push;
        logic pop;
        logic ret_int;
        logic [TARGET_W-1:0] target;
    } branch_req_t;

    typedef struct packed {
        phase_t phase;
        logic [INSTR_W-1:0] ir;
        logic flush;
        logic [DATA_W-1:0] w;
        status_t st;
        logic take;
        logic rd_en;
        logic wr_en;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic skip;
        branch_req_t branch;
        logic standby;
        logic wdt_clr;
        logic [2:0] wake_s;
    } core_state_t;

    // Values after reset; phase starts at the last slot so a fetch follows at once
    localparam phase_t PHASE_RST = PH_WRITE;
    localparam status_t STATUS_RST = 5'h18;

endpackage : instr_dec_pkg

// ===== logic/instr_dec.sv
/*
 * Four-phase decoder and sequencer for 14-bit instruction words.
 * Assumes program memory presents the next word on INSTR while TAKE is
 * high, and the register file answers RDATA in the cycle after RD_EN.
 */
`timescale 1ns/100ps
`default_nettype none

module instr_dec (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [instr_dec_pkg::INSTR_W-1:0] INSTR,
    input wire logic [instr_dec_pkg::DATA_W-1:0] RDATA,
    input wire logic WAKE,
    output logic TAKE,
    output logic RD_EN,
    output logic WR_EN,
    output logic [instr_dec_pkg::FADDR_W-1:0] ADDR,
    output logic [instr_dec_pkg::DATA_W-1:0] WDATA,
    output logic [instr_dec_pkg::DATA_W-1:0] ACC,
    output instr_dec_pkg::status_t FLAGS,
    output logic SKIP,
    output instr_dec_pkg::branch_req_t BRANCH,
    output logic STANDBY,
    output logic WDT_CLR
);
    import instr_dec_pkg::*;

    core_state_t q;
    core_state_t n;
    logic [DATA_W-1:0] opnd;
    logic [DATA_W:0] add_s;
    logic [DATA_W:0] sub_s;
    logic [4:0] add_h;
    logic [4:0] sub_h;
    logic [DATA_W-1:0] res;
    logic wb;
    logic wa;
    logic zf;
    logic cf;
    logic hf;
    logic cv;
    logic hv;
    logic sk;
    logic fl;
    logic file_op;
    logic exec;
    logic [2:0] bsel;
    logic [DATA_W-1:0] swp;

    // Current instruction executes only in its third phase and when not flushed
    assign exec = (q.phase == PH_EXEC) && !q.flush && !q.standby;
    assign bsel = q.ir[9:7];
    assign swp = {RDATA[3:0], RDATA[7:4]};

    // Every file-register form reads its register, even clear and store
    assign file_op = (INSTR[13] == 1'b0) && !(INSTR[13:9] == 5'h00 && !INSTR[7]); // RULE7 RULE8

    // Shared adder for register and literal forms; carry is no-borrow on subtract
    always_comb begin
        opnd = (q.ir[13:12] == GRP_LIT) ? q.ir[7:0] : RDATA; // RULE4
        add_s = 9'(q.w) + 9'(opnd);
        add_h = 5'(q.w[3:0]) + 5'(opnd[3:0]);
        // Invert at eight and four bits first so the zero-extension stays a zero
        sub_s = 9'(opnd) + {1'b0, ~q.w} + 9'h001;
        sub_h = 5'(opnd[3:0]) + {1'b0, ~q.w[3:0]} + 5'h01;
    end

    // Next-state logic for the whole sequencer
    always_comb begin
        res = RDATA;
        wb = 1'b0;
        wa = 1'b0;
        zf = 1'b0;
        cf = 1'b0;
        hf = 1'b0;
        cv = q.st.c;
        hv = q.st.digit_carry_flag;
        sk = 1'b0;
        fl = 1'b0;
        n = q;
        n.take = 1'b0;
        n.rd_en = 1'b0;
        n.wr_en = 1'b0;
        n.skip = 1'b0;
        n.branch = '0;
        n.wdt_clr = 1'b0;
        n.wake_s = {q.wake_s[1:0], WAKE};

        // Four phases per instruction cycle; standby freezes the last phase
        if (!q.standby) begin
            n.phase = phase_t'(2'(q.phase + 2'h1)); // RULE5
        end else if (q.wake_s[2] && q.wake_s[1]) begin
            n.standby = 1'b0;
            n.phase = PH_FETCH;
        end
        n.take = (q.phase == PH_WRITE) && (n.phase == PH_FETCH);

        // Latch the word; a flushed slot issues no read
        if (q.take) begin
            n.ir = INSTR; // RULE1
            n.addr = INSTR[6:0]; // RULE3
            n.rd_en = !q.flush && file_op; // RULE7 RULE8
        end

        if (exec) begin
            unique case (q.ir[13:12])
                GRP_BYTE: begin
                    wb = q.ir[7]; // RULE2
                    wa = !q.ir[7]; // RULE2
                    unique case (q.ir[11:8])
                        OP_MISC: begin
                            // Bit 7 set stores the accumulator, no flags
                            res = q.w; // RULE15
                            wa = 1'b0;
                            if (!q.ir[7]) begin
                                case (q.ir[7:0])
                                    MISC_STANDBY: begin
                                        n.standby = 1'b1; // RULE17
                                        n.st.timeout_status_bit = 1'b1;
                                        n.st.powerdown_status_bit = 1'b0;
                                    end
                                    MISC_WDT_CLEAR: begin
                                        n.wdt_clr = 1'b1;
                                        n.st.timeout_status_bit = 1'b1;
                                        n.st.powerdown_status_bit = 1'b1;
                                    end
                                    MISC_RETURN: begin
                                        n.branch.pop = 1'b1;
                                        fl = 1'b1; // RULE6
                                    end
                                    MISC_RET_INT: begin
                                        n.branch.pop = 1'b1;
                                        n.branch.ret_int = 1'b1;
                                        fl = 1'b1; // RULE6
                                    end
                                    // Idle word; the x bits of it are not looked at
                                    default: res = q.w; // RULE9 RULE15
                                endcase
                            end
                        end
                        OP_CLEAR: begin
                            // Low seven bits are don't-care when clearing the accumulator
                            res = '0; // RULE9 RULE14
                            zf = 1'b1;
                        end
                        OP_SUB: begin
                            res = sub_s[7:0]; // RULE10
                            {zf, cf, hf} = 3'h7;
                            cv = sub_s[8];
                            hv = sub_h[4];
                        end
                        OP_ADD: begin
                            res = add_s[7:0]; // RULE10
                            {zf, cf, hf} = 3'h7;
                            cv = add_s[8];
                            hv = add_h[4];
                        end
                        OP_OR: begin
                            res = q.w | opnd; // RULE11
                            zf = 1'b1;
                        end
                        OP_AND: begin
                            res = q.w & opnd; // RULE11
                            zf = 1'b1;
                        end
                        OP_XOR: begin
                            res = q.w ^ opnd; // RULE11
                            zf = 1'b1;
                        end
                        OP_DEC: begin
                            res = RDATA - 8'h01; // RULE14
                            zf = 1'b1;
                        end
                        OP_INC: begin
                            res = RDATA + 8'h01; // RULE14
                            zf = 1'b1;
                        end
                        OP_COMPL: begin
                            res = ~RDATA; // RULE14
                            zf = 1'b1;
                        end
                        OP_MOVE: zf = 1'b1; // RULE14
                        OP_DEC_SKIP: begin
                            res = RDATA - 8'h01; // RULE13
                            sk = (res == 8'h00);
                        end
                        OP_INC_SKIP: begin
                            res = RDATA + 8'h01; // RULE13
                            sk = (res == 8'h00);
                        end
                        OP_ROT_RIGHT: begin
                            res = {q.st.c, RDATA[7:1]}; // RULE12
                            cf = 1'b1;
                            cv = RDATA[0];
                        end
                        OP_ROT_LEFT: begin
                            res = {RDATA[6:0], q.st.c}; // RULE12
                            cf = 1'b1;
                            cv = RDATA[7];
                        end
                        OP_SWAP: res = swp; // RULE15
                    endcase
                end
                GRP_BIT: begin
                    unique case (q.ir[11:10])
                        BIT_CLEAR: begin
                            res[bsel] = 1'b0; // RULE16
                            wb = 1'b1;
                        end
                        BIT_SET: begin
                            res[bsel] = 1'b1; // RULE16
                            wb = 1'b1;
                        end
                        BIT_SKIP_CLR: sk = !RDATA[bsel]; // RULE16
                        BIT_SKIP_SET: sk = RDATA[bsel]; // RULE16
                    endcase
                end
                GRP_BRANCH: begin
                    // Call pushes, goto does not; the 11-bit target goes out
                    n.branch.jump = 1'b1;
                    n.branch.push = !q.ir[11];
                    n.branch.target = q.ir[10:0]; // RULE4
                    fl = 1'b1; // RULE6
                end
                GRP_LIT: begin
                    wa = 1'b1;
                    res = opnd;
                    unique case (q.ir[11:10])
                        LIT_MOVE: res = opnd; // RULE9
                        LIT_RETURN: begin
                            n.branch.pop = 1'b1;
                            fl = 1'b1; // RULE6
                        end
                        LIT_LOGIC: begin
                            zf = 1'b1;
                            unique case (q.ir[9:8])
                                2'h0: res = q.w | opnd;
                                2'h1: res = q.w & opnd;
                                2'h2: res = q.w ^ opnd;
                                2'h3: {wa, zf} = 2'h0; // Unassigned code acts as idle
                            endcase
                        end
                        LIT_ARITH: begin
                            // Bit 8 is don't-care for the add and subtract forms
                            res = q.ir[9] ? add_s[7:0] : sub_s[7:0]; // RULE9
                            {zf, cf, hf} = 3'h7;
                            cv = q.ir[9] ? add_s[8] : sub_s[8];
                            hv = q.ir[9] ? add_h[4] : sub_h[4];
                        end
                    endcase
                end
            endcase

            // Commit the result to one destination and the flags it touches
            n.wr_en = wb; // RULE2
            n.wdata = res;
            if (wa) begin
                n.w = res; // RULE2
            end
            if (zf) begin
                n.st.z = (res == 8'h00);
            end
            if (cf) begin
                n.st.c = cv;
            end
            if (hf) begin
                n.st.digit_carry_flag = hv;
            end
            // The following slot runs idle after a skip or a flow change
            n.skip = sk;
            n.flush = sk | fl; // RULE6
        end else if (q.phase == PH_EXEC && !q.standby) begin
            n.flush = 1'b0; // RULE6
        end
    end

    // Single state register; reset starts a fetch on the following cycle
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            q <= '0;
            q.phase <= PHASE_RST;
            q.st <= STATUS_RST;
        end else begin
            q <= n;
        end
    end

    assign TAKE = q.take;
    assign RD_EN = q.rd_en;
    assign WR_EN = q.wr_en;
    assign ADDR = q.addr;
    assign WDATA = q.wdata;
    assign ACC = q.w;
    assign FLAGS = q.st;
    assign SKIP = q.skip;
    assign BRANCH = q.branch;
    assign STANDBY = q.standby;
    assign WDT_CLR = q.wdt_clr;

    default clocking dc_core @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_cycle_four: assert property (TAKE |-> ##4 (TAKE || STANDBY)) // RULE5
        else $error("instruction cycle is not four clocks");
    a_read_first: assert property (WR_EN |-> $past(RD_EN, 2)) // RULE7
        else $error("register written without a prior read");
    a_dest_file: assert property (WR_EN && q.ir[13:12] == GRP_BYTE |-> q.ir[7]) // RULE2
        else $error("byte op wrote the register with destination 0");
    a_acc_kept: assert property (exec && q.ir[13:12] == GRP_BYTE && q.ir[7] |=> $stable(ACC)) // RULE2
        else $error("accumulator changed with destination 1");
    a_addr_field: assert property (RD_EN |-> ADDR == q.ir[6:0]) // RULE3
        else $error("read address differs from the address field");
    a_skip_idle: assert property (SKIP |-> ##2 !RD_EN ##2 !WR_EN) // RULE6
        else $error("instruction after a skip was not idle");
    a_skip_flags: assert property (exec && q.ir[13:12] == GRP_BYTE
        && (q.ir[11:8] == OP_DEC_SKIP || q.ir[11:8] == OP_INC_SKIP) |=> $stable(FLAGS)) // RULE13
        else $error("skip-if-zero changed a status flag");
    a_logic_zero: assert property (exec && q.ir[13:12] == GRP_BYTE && q.ir[11:8] == OP_XOR
        |=> $stable(FLAGS.c) && $stable(FLAGS.digit_carry_flag)) // RULE11
        else $error("logic op touched carry flags");
    a_rotate_only: assert property (exec && q.ir[13:12] == GRP_BYTE && q.ir[11:8] == OP_ROT_LEFT
        |=> $stable(FLAGS.z) && FLAGS.c == $past(RDATA[7])) // RULE12
        else $error("rotate left flags wrong");
    a_swap_value: assert property (exec && q.ir[13:12] == GRP_BYTE && q.ir[11:8] == OP_SWAP
        |=> WDATA == $past(swp)) // RULE15
        else $error("swap result wrong");
    a_standby_entry: assert property (exec && q.ir == 14'h0063
        |=> STANDBY && !FLAGS.powerdown_status_bit && FLAGS.timeout_status_bit) // RULE17
        else $error("standby word did not enter standby");

endmodule : instr_dec

`default_nettype wire

// ===== verif/reg_prog_model.sv
/*
 * Partner model: program memory and register file facing the decoder.
 * Assumes one word per fetch strobe and read data one cycle after RD_EN.
 */
`timescale 1ns/100ps
`default_nettype none

module reg_prog_model (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic TAKE,
    input wire logic RD_EN,
    input wire logic WR_EN,
    input wire logic [6:0] ADDR,
    input wire logic [7:0] WDATA,
    output logic [13:0] INSTR,
    output logic [7:0] RDATA
);
    logic [13:0] prog [0:15];
    logic [7:0] regs [0:127];
    int rd_cnt [0:127];
    logic [3:0] pc_q;
    logic rd_q;
    logic [7:0] last_q = 8'ha5;

    // Outside its slot each bus shows junk, so a late sample cannot pass by luck
    assign INSTR = TAKE ? prog[pc_q] : ~prog[pc_q];
    assign RDATA = rd_q ? regs[ADDR] : ~last_q;

    // Program counter is linear; the decoder itself drops flushed slots
    always @(posedge CLK_SYS) begin
        rd_q <= RD_EN;
        if (rd_q) last_q <= regs[ADDR];
        if (RST) pc_q <= 4'h0;
        else if (TAKE) pc_q <= pc_q + 4'h1;
        if (RD_EN) rd_cnt[ADDR] <= rd_cnt[ADDR] + 1;
        if (WR_EN) regs[ADDR] <= WDATA;
    end
endmodule : reg_prog_model

`default_nettype wire

// ===== verif/instr_dec_bench.sv
/*
 * Self-checking bench for the instruction decoder: runs short programs
 * held in the partner model. Assumes a 50 MHz core clock.
 */
`timescale 1ns/100ps
`default_nettype none

module instr_dec_bench;
    import instr_dec_pkg::*;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic WAKE = 1'b0;
    logic [13:0] INSTR;
    logic [7:0] RDATA, WDATA, ACC;
    logic [6:0] ADDR;
    logic TAKE, RD_EN, WR_EN, SKIP, STANDBY, WDT_CLR;
    status_t FLAGS;
    branch_req_t BRANCH;
    logic [10:0] tgt;
    int mismatches = 0;
    int num_checks = 0;
    int skips = 0;
    int reads = 0;
    int wdts = 0;

    instr_dec dut (.CLK_SYS(CLK_SYS), .RST(RST), .INSTR(INSTR), .RDATA(RDATA), .WAKE(WAKE),
        .TAKE(TAKE), .RD_EN(RD_EN), .WR_EN(WR_EN), .ADDR(ADDR), .WDATA(WDATA), .ACC(ACC),
        .FLAGS(FLAGS), .SKIP(SKIP), .BRANCH(BRANCH), .STANDBY(STANDBY), .WDT_CLR(WDT_CLR));
    reg_prog_model mem (.CLK_SYS(CLK_SYS), .RST(RST), .TAKE(TAKE), .RD_EN(RD_EN),
        .WR_EN(WR_EN), .ADDR(ADDR), .WDATA(WDATA), .INSTR(INSTR), .RDATA(RDATA));

    initial begin
        forever #10 CLK_SYS = ~CLK_SYS;
    end

    // Strobes are counted at the falling edge, where they are settled
    always @(negedge CLK_SYS) begin
        if (SKIP === 1'b1) skips++;
        if (RD_EN === 1'b1) reads++;
        if (WDT_CLR === 1'b1) wdts++;
        if (BRANCH.jump === 1'b1) tgt = BRANCH.target;
    end

    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic fail(input string msg);
        mismatches++;
        $display("Error at %0t ns: %s", $time, msg);
    endtask : fail

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) fail($sformatf("%s got %h want %h", what, got, exp));
    endtask : chk_val

    task automatic chk_flags(input status_t got, input status_t exp);
        num_checks++;
        if (got !== exp) fail($sformatf("flags got %b want %b", got, exp));
    endtask : chk_flags

    task automatic chk_count(input int got, input int exp, input string what);
        num_checks++;
        if (got != exp) fail($sformatf("%s count %0d want %0d", what, got, exp));
    endtask : chk_count

    function automatic logic [13:0] bop(input logic [3:0] op, input logic d, input logic [6:0] f);
        return {GRP_BYTE, op, d, f};
    endfunction : bop

    function automatic logic [13:0] lit(input logic [7:0] k);
        return {GRP_LIT, LIT_MOVE, 2'b00, k};
    endfunction : lit

    // Blank program, then reset for two cycles; caller loads memory at once
    task automatic start;
        for (int i = 0; i < 16; i++) mem.prog[i] = 14'h0000;
        for (int i = 0; i < 128; i++) mem.rd_cnt[i] = 0;
        @(negedge CLK_SYS);
        RST = 1'b1;
        repeat (2) @(negedge CLK_SYS);
        RST = 1'b0;
        skips = 0;
        reads = 0;
        wdts = 0;
    endtask : start

    // Let n words be fetched, then let the last one finish its cycle
    task automatic run_words(input int n);
        int seen;
        seen = 0;
        for (int i = 0; i < 20 * n && seen < n; i++) begin
            @(negedge CLK_SYS);
            if (TAKE === 1'b1) seen++;
        end
        if (seen < n) begin
            fail("fetch never came");
            complete_run();
        end
        repeat (3) @(negedge CLK_SYS);
    endtask : run_words

    task automatic s_arith;
        start();
        mem.regs[5] = 8'hc8;
        mem.regs[6] = 8'h02;
        mem.prog[0] = lit(8'h3a);
        mem.prog[1] = bop(OP_ADD, 1'b0, 7'h05);
        mem.prog[3] = bop(OP_SUB, 1'b1, 7'h06);
        run_words(3);
        chk_val(ACC, 8'h02, "add acc");
        chk_flags(FLAGS, 5'h1b);
        run_words(2);
        chk_val(mem.regs[6], 8'h00, "sub reg");
        chk_val(ACC, 8'h02, "sub acc");
        chk_flags(FLAGS, 5'h1f);
    endtask : s_arith

    // Carry is set first so that a logic op touching it shows
    task automatic s_logic;
        logic [3:0] ops [3] = '{OP_OR, OP_AND, OP_XOR};
        logic [7:0] res [3] = '{8'hff, 8'h00, 8'hff};
        for (int i = 0; i < 3; i++) begin
            start();
            mem.regs[7'h10] = 8'hf0;
            mem.regs[7'h11] = 8'h81;
            mem.prog[0] = lit(8'h80);
            mem.prog[1] = bop(OP_ADD, 1'b0, 7'h11);
            mem.prog[2] = lit(8'h0f);
            mem.prog[3] = bop(ops[i], 1'b0, 7'h10);
            run_words(5);
            chk_val(ACC, res[i], "logic acc");
            chk_flags(FLAGS, res[i] == 8'h00 ? 5'h1d : 5'h19);
        end
    endtask : s_logic

    task automatic s_rotate;
        start();
        mem.regs[7'h20] = 8'h81;
        mem.regs[7'h21] = 8'h10;
        mem.regs[7'h22] = 8'h3c;
        mem.prog[0] = bop(OP_ROT_LEFT, 1'b1, 7'h20);
        mem.prog[1] = bop(OP_ROT_RIGHT, 1'b1, 7'h21);
        mem.prog[2] = bop(OP_SWAP, 1'b0, 7'h22);
        run_words(4);
        chk_val(mem.regs[7'h20], 8'h02, "rotate left");
        chk_val(mem.regs[7'h21], 8'h88, "rotate right");
        chk_val(ACC, 8'hc3, "swap");
        chk_val(mem.regs[7'h22], 8'h3c, "swap source");
        chk_flags(FLAGS, 5'h18);
    endtask : s_rotate

    // Words after a taken skip must have no effect
    task automatic s_skip;
        start();
        mem.regs[7'h30] = 8'h01;
        mem.regs[7'h31] = 8'hff;
        mem.regs[7'h32] = 8'h05;
        mem.prog[0] = bop(OP_DEC_SKIP, 1'b1, 7'h30);
        mem.prog[1] = lit(8'h55);
        mem.prog[2] = bop(OP_INC_SKIP, 1'b0, 7'h31);
        mem.prog[3] = lit(8'h66);
        mem.prog[5] = bop(OP_DEC_SKIP, 1'b1, 7'h32);
        mem.prog[6] = lit(8'h77);
        run_words(5);
        chk_val(ACC, 8'h00, "flushed word");
        chk_flags(FLAGS, 5'h18);
        chk_count(skips, 2, "skip");
        run_words(3);
        chk_val(ACC, 8'h77, "no skip");
        chk_val(mem.regs[7'h30], 8'h00, "dec skip");
        chk_val(mem.regs[7'h32], 8'h04, "dec no skip");
        chk_count(skips, 2, "skip");
    endtask : s_skip

    task automatic s_rmw;
        start();
        mem.regs[7'h7f] = 8'ha5;
        mem.regs[7'h00] = 8'h3c;
        mem.prog[0] = bop(OP_CLEAR, 1'b1, 7'h7f);
        mem.prog[1] = lit(8'h99);
        mem.prog[2] = bop(OP_MISC, 1'b1, 7'h00);
        mem.prog[3] = bop(OP_MOVE, 1'b0, 7'h7f);
        run_words(5);
        chk_count(mem.rd_cnt[127], 2, "clear read");
        chk_count(mem.rd_cnt[0], 1, "store read");
        chk_val(mem.regs[7'h7f], 8'h00, "clear");
        chk_val(mem.regs[7'h00], 8'h99, "store");
        chk_val(ACC, 8'h00, "move");
        chk_flags(FLAGS, 5'h1c);
    endtask : s_rmw

    // Don't-care bits set, an idle word, and a jump with a flushed slot
    task automatic s_dontcare;
        start();
        mem.prog[0] = 14'h3355;
        mem.prog[1] = 14'h0060;
        mem.prog[2] = 14'h2da3;
        mem.prog[3] = lit(8'h11);
        run_words(5);
        chk_val(ACC, 8'h55, "literal");
        chk_count(reads, 0, "idle read");
        chk_val(tgt[7:0], 8'ha3, "target low");
        chk_val({5'b00000, tgt[10:8]}, 8'h05, "target high");
        chk_flags(FLAGS, 5'h18);
    endtask : s_dontcare

    // Bit set and clear, then skip-if-set taken and skip-if-clear not taken and taken
    task automatic s_bits;
        start();
        mem.regs[7'h40] = 8'h0f;
        mem.prog[0] = {GRP_BIT, BIT_SET, 3'h7, 7'h40};
        mem.prog[1] = {GRP_BIT, BIT_CLEAR, 3'h0, 7'h40};
        mem.prog[2] = {GRP_BIT, BIT_SKIP_SET, 3'h7, 7'h40};
        mem.prog[3] = lit(8'h12);
        mem.prog[4] = {GRP_BIT, BIT_SKIP_CLR, 3'h1, 7'h40};
        mem.prog[5] = lit(8'h34);
        mem.prog[6] = {GRP_BIT, BIT_SKIP_CLR, 3'h0, 7'h40};
        mem.prog[7] = lit(8'h56);
        run_words(9);
        chk_val(mem.regs[7'h40], 8'h8e, "bit set clear");
        chk_val(ACC, 8'h34, "bit skip");
        chk_count(skips, 2, "bit skip");
        chk_flags(FLAGS, 5'h18);
    endtask : s_bits

    task automatic s_standby;
        int n;
        start();
        mem.prog[0] = {GRP_BYTE, OP_MISC, MISC_STANDBY};
        mem.prog[1] = lit(8'h42);
        // Watchdog clear after wake raises the power-down bit again
        mem.prog[2] = {GRP_BYTE, OP_MISC, MISC_WDT_CLEAR};
        run_words(1);
        n = 0;
        repeat (12) begin
            @(negedge CLK_SYS);
            if (TAKE === 1'b1) n++;
        end
        chk_val({7'h00, STANDBY}, 8'h01, "standby");
        chk_flags(FLAGS, 5'h10);
        chk_count(n, 0, "fetch in standby");
        WAKE = 1'b1;
        for (n = 0; n < 10 && TAKE !== 1'b1; n++) @(negedge CLK_SYS);
        chk_val({7'h00, TAKE}, 8'h01, "wake fetch");
        for (n = 1; n < 9; n++) begin
            @(negedge CLK_SYS);
            if (TAKE === 1'b1) break;
        end
        chk_count(n, CYCLE_CLKS, "cycle length");
        WAKE = 1'b0;
        run_words(1);
        chk_val(ACC, 8'h42, "after wake");
        chk_count(wdts, 1, "watchdog clear");
        chk_flags(FLAGS, 5'h18);
    endtask : s_standby

    initial begin
        s_arith();
        s_logic();
        s_rotate();
        s_skip();
        s_rmw();
        s_dontcare();
        s_bits();
        s_standby();
        complete_run();
    end
endmodule : instr_dec_bench

`default_nettype wire
